// *** hw/trace_tick_gen.sv ***
`timescale 1ns/100ps
module trace_tick_gen #(
    parameter int unsigned BASE_CYCLES = trace_trigger_pkg::TIME_BASE_CYCLES
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // control
    input  wire logic        run,
    input  wire logic [13:0] multiplier,
    // tick out
    output logic             sample_tick
);
    // refused at elaboration: the base counter is 16 bits wide
    if (BASE_CYCLES < 2 || BASE_CYCLES > 65536) begin : g_bad_base
        $error("trace_tick_gen: BASE_CYCLES out of range");
    end

    typedef struct packed {
        logic [15:0] base_cnt;
        logic [13:0] mult_cnt;
        logic        tick;
    } tick_state_t;

    tick_state_t st_r;
    tick_state_t st_nxt;

    localparam logic [15:0] BASE_LAST = 16'(BASE_CYCLES - 1);

    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (!run) begin
            st_nxt.base_cnt = 16'h0000;
            st_nxt.mult_cnt = 14'h0000;
        end else if (st_r.base_cnt == BASE_LAST) begin
            st_nxt.base_cnt = 16'h0000;
            // a period change takes hold at the next base edge
            if (st_r.mult_cnt + 14'h0001 >= multiplier) begin
                st_nxt.mult_cnt = 14'h0000;
                st_nxt.tick     = 1'b1;
            end else begin
                st_nxt.mult_cnt = st_r.mult_cnt + 14'h0001;
            end
        end else begin
            st_nxt.base_cnt = st_r.base_cnt + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sample_tick = st_r.tick;

    a_tick_base_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.tick |-> $past(st_r.base_cnt) == BASE_LAST)
        else $error("sample tick off the time base edge");
endmodule

// *** hw/trace_trigger_pkg.sv ***
package trace_trigger_pkg;
    // clock and time base
    localparam int unsigned CLK_PERIOD_PS     = 8000;
    localparam int unsigned TIME_BASE_US      = 500;
    localparam int unsigned TIME_BASE_CYCLES  = (TIME_BASE_US * 1000 * 1000) / CLK_PERIOD_PS;

    // register byte offsets
    localparam logic [7:0] OFS_SPECIAL_FUNC   = 8'h00;
    localparam logic [7:0] OFS_SOURCE_SEL     = 8'h04;
    localparam logic [7:0] OFS_COMPARE_VAL    = 8'h08;
    localparam logic [7:0] OFS_CONDITION_SEL  = 8'h0c;
    localparam logic [7:0] OFS_SAMPLE_MULT    = 8'h10;
    localparam logic [7:0] OFS_PRETRIG_PCT    = 8'h14;
    localparam logic [7:0] OFS_CONTROL        = 8'h18;
    localparam logic [7:0] OFS_STATUS         = 8'h1c;

    // reset values
    localparam logic [1:0]  RST_SPECIAL_FUNC  = 2'h0;
    localparam logic [9:0]  RST_SOURCE_SEL    = 10'h000;
    localparam logic [15:0] RST_COMPARE_VAL   = 16'h0000;
    localparam logic [4:0]  RST_CONDITION_SEL = 5'h04;
    localparam logic [13:0] RST_SAMPLE_MULT   = 14'h0004;
    localparam logic [6:0]  RST_PRETRIG_PCT   = 7'h32;

    // limits
    localparam logic [9:0]  MAX_SOURCE_SEL    = 10'h3e7;
    localparam logic [4:0]  MAX_CONDITION_SEL = 5'h15;
    localparam logic [13:0] MIN_SAMPLE_MULT   = 14'h0001;
    localparam logic [13:0] MAX_SAMPLE_MULT   = 14'h270f;
    localparam logic [6:0]  MAX_PRETRIG_PCT   = 7'h64;

    // special function codes that enable tracing
    localparam logic [1:0]  SF_TRACE          = 2'h2;
    localparam logic [1:0]  SF_TRACE_PID      = 2'h3;

    // source codes: no source, and the two that carry status words
    localparam logic [9:0]  SRC_NONE          = 10'h000;
    localparam logic [9:0]  SRC_DIN_STATUS    = 10'h00b;
    localparam logic [9:0]  SRC_DOUT_STATUS   = 10'h00c;

    // trigger conditions
    localparam logic [4:0]  COND_EQ           = 5'h00;
    localparam logic [4:0]  COND_NE           = 5'h01;
    localparam logic [4:0]  COND_GT           = 5'h02;
    localparam logic [4:0]  COND_LT           = 5'h03;
    localparam logic [4:0]  COND_FAULT        = 5'h04;
    localparam logic [4:0]  COND_BIT0         = 5'h05;
    localparam logic [4:0]  COND_BIT15        = 5'h14;
    localparam logic [4:0]  COND_FORCE        = 5'h15;

    // control and status bits
    localparam int unsigned CTL_ARM_BIT       = 0;
    localparam int unsigned STS_ARMED_BIT     = 0;
    localparam int unsigned STS_TRIG_BIT      = 1;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_FIRED = 2'b10
    } trig_state_t;
endpackage

// *** hw/trace_trigger_sampler.sv ***
`timescale 1ns/100ps
module trace_trigger_sampler #(
    parameter int unsigned BASE_CYCLES = trace_trigger_pkg::TIME_BASE_CYCLES
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // process quantities
    input  wire logic [15:0] source_value,
    input  wire logic        fault_active,
    // source select to the quantity mux
    output logic [9:0]       source_select,
    // trace recorder side
    output logic             trace_enable,
    output logic             sample_tick,
    output logic             trigger_event,
    output logic             triggered,
    output logic [6:0]       pretrigger_percent
);
    typedef struct packed {
        logic [1:0]                    special_function_select;
        logic [9:0]                    trigger_source_select;
        logic [15:0]                   trigger_compare_value;
        logic [4:0]                    trigger_condition_select;
        logic [13:0]                   sample_period_multiplier;
        logic [6:0]                    pretrigger_percent;
        trace_trigger_pkg::trig_state_t state;
        logic                          trig_pulse;
        logic                          aw_held;
        logic [7:0]                    aw_addr;
        logic                          w_held;
        logic [31:0]                   w_data;
        logic [3:0]                    w_strb;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          rvalid;
        logic [31:0]                   rdata;
        logic [1:0]                    rresp;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;

    logic tracing;
    logic tick;
    logic cond_true;
    logic [3:0] bit_idx;
    logic [15:0] wmask;
    logic [15:0] wval;

    assign tracing = (st_r.special_function_select == trace_trigger_pkg::SF_TRACE) ||
                     (st_r.special_function_select == trace_trigger_pkg::SF_TRACE_PID);

    trace_tick_gen #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_tick (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .run         (tracing),
        .multiplier  (st_r.sample_period_multiplier),
        .sample_tick (tick)
    );

    // condition evaluation
    always_comb begin
        bit_idx   = 4'(st_r.trigger_condition_select - trace_trigger_pkg::COND_BIT0);
        cond_true = 1'b0;
        case (st_r.trigger_condition_select)
            trace_trigger_pkg::COND_EQ: begin
                cond_true = $signed(source_value) == $signed(st_r.trigger_compare_value);
            end
            trace_trigger_pkg::COND_NE: begin
                cond_true = $signed(source_value) != $signed(st_r.trigger_compare_value);
            end
            trace_trigger_pkg::COND_GT: begin
                cond_true = $signed(source_value) > $signed(st_r.trigger_compare_value);
            end
            trace_trigger_pkg::COND_LT: begin
                cond_true = $signed(source_value) < $signed(st_r.trigger_compare_value);
            end
            trace_trigger_pkg::COND_FAULT: begin
                cond_true = fault_active;
            end
            trace_trigger_pkg::COND_FORCE: begin
                cond_true = 1'b1;
            end
            default: begin
                // bit tests only make sense on the status word sources
                if (st_r.trigger_condition_select <= trace_trigger_pkg::COND_BIT15 &&
                    (st_r.trigger_source_select == trace_trigger_pkg::SRC_DIN_STATUS ||
                     st_r.trigger_source_select == trace_trigger_pkg::SRC_DOUT_STATUS)) begin
                    cond_true = source_value[bit_idx];
                end
            end
        endcase
        // no source means nothing to compare; fault and force still apply
        if (st_r.trigger_source_select == trace_trigger_pkg::SRC_NONE &&
            st_r.trigger_condition_select != trace_trigger_pkg::COND_FAULT &&
            st_r.trigger_condition_select != trace_trigger_pkg::COND_FORCE) begin
            cond_true = 1'b0;
        end
    end

    always_comb begin
        wmask = {{8{st_r.w_strb[1]}}, {8{st_r.w_strb[0]}}};
        wval  = st_r.w_data[15:0];
        st_nxt = st_r;
        st_nxt.trig_pulse = 1'b0;

        // trigger state machine
        case (st_r.state)
            trace_trigger_pkg::ST_IDLE: begin
                if (tracing) begin
                    st_nxt.state = trace_trigger_pkg::ST_ARMED;
                end
            end
            trace_trigger_pkg::ST_ARMED: begin
                if (!tracing) begin
                    st_nxt.state = trace_trigger_pkg::ST_IDLE;
                end else if (tick && cond_true) begin
                    st_nxt.state      = trace_trigger_pkg::ST_FIRED;
                    st_nxt.trig_pulse = 1'b1;
                end
            end
            trace_trigger_pkg::ST_FIRED: begin
                if (!tracing) begin
                    st_nxt.state = trace_trigger_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt.state = trace_trigger_pkg::ST_IDLE;
            end
        endcase

        // write channel capture
        if (s_axi_awvalid && !st_r.aw_held) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_held) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end

        if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = 2'h0;
            // out-of-range values are refused with slverr, register kept
            case (st_r.aw_addr)
                trace_trigger_pkg::OFS_SPECIAL_FUNC: begin
                    if (st_r.w_strb[0]) st_nxt.special_function_select = wval[1:0];
                end
                trace_trigger_pkg::OFS_SOURCE_SEL: begin
                    if (wval > 16'(trace_trigger_pkg::MAX_SOURCE_SEL)) st_nxt.bresp = 2'h2;
                    else st_nxt.trigger_source_select = (wval[9:0] & wmask[9:0]) |
                                                        (st_r.trigger_source_select & ~wmask[9:0]);
                end
                trace_trigger_pkg::OFS_COMPARE_VAL: begin
                    st_nxt.trigger_compare_value = (wval & wmask) | (st_r.trigger_compare_value & ~wmask);
                end
                trace_trigger_pkg::OFS_CONDITION_SEL: begin
                    if (wval > 16'(trace_trigger_pkg::MAX_CONDITION_SEL)) st_nxt.bresp = 2'h2;
                    else if (st_r.w_strb[0]) st_nxt.trigger_condition_select = wval[4:0];
                end
                trace_trigger_pkg::OFS_SAMPLE_MULT: begin
                    if (wval < 16'(trace_trigger_pkg::MIN_SAMPLE_MULT) ||
                        wval > 16'(trace_trigger_pkg::MAX_SAMPLE_MULT)) st_nxt.bresp = 2'h2;
                    else st_nxt.sample_period_multiplier = (wval[13:0] & wmask[13:0]) |
                                                          (st_r.sample_period_multiplier & ~wmask[13:0]);
                end
                trace_trigger_pkg::OFS_PRETRIG_PCT: begin
                    if (wval > 16'(trace_trigger_pkg::MAX_PRETRIG_PCT)) st_nxt.bresp = 2'h2;
                    else if (st_r.w_strb[0]) st_nxt.pretrigger_percent = wval[6:0];
                end
                trace_trigger_pkg::OFS_CONTROL: begin
                    // rearm only once fired, so a rearm never swallows a fire in the same cycle
                    if (st_r.w_strb[0] && wval[trace_trigger_pkg::CTL_ARM_BIT] && tracing &&
                        st_r.state == trace_trigger_pkg::ST_FIRED) begin
                        st_nxt.state = trace_trigger_pkg::ST_ARMED;
                    end
                end
                default: begin
                    st_nxt.bresp = 2'h2;
                end
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // read channel
        if (s_axi_arvalid && !st_r.rvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = 2'h0;
            st_nxt.rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                trace_trigger_pkg::OFS_SPECIAL_FUNC:  st_nxt.rdata[1:0]  = st_r.special_function_select;
                trace_trigger_pkg::OFS_SOURCE_SEL:    st_nxt.rdata[9:0]  = st_r.trigger_source_select;
                trace_trigger_pkg::OFS_COMPARE_VAL:   st_nxt.rdata[15:0] = st_r.trigger_compare_value;
                trace_trigger_pkg::OFS_CONDITION_SEL: st_nxt.rdata[4:0]  = st_r.trigger_condition_select;
                trace_trigger_pkg::OFS_SAMPLE_MULT:   st_nxt.rdata[13:0] = st_r.sample_period_multiplier;
                trace_trigger_pkg::OFS_PRETRIG_PCT:   st_nxt.rdata[6:0]  = st_r.pretrigger_percent;
                trace_trigger_pkg::OFS_CONTROL:       st_nxt.rdata       = 32'h0000_0000;
                trace_trigger_pkg::OFS_STATUS: begin
                    st_nxt.rdata[trace_trigger_pkg::STS_ARMED_BIT] = st_r.state == trace_trigger_pkg::ST_ARMED;
                    st_nxt.rdata[trace_trigger_pkg::STS_TRIG_BIT]  = st_r.state == trace_trigger_pkg::ST_FIRED;
                end
                default: st_nxt.rresp = 2'h2;
            endcase
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.special_function_select  <= trace_trigger_pkg::RST_SPECIAL_FUNC;
            st_r.trigger_source_select    <= trace_trigger_pkg::RST_SOURCE_SEL;
            st_r.trigger_compare_value    <= trace_trigger_pkg::RST_COMPARE_VAL;
            st_r.trigger_condition_select <= trace_trigger_pkg::RST_CONDITION_SEL;
            st_r.sample_period_multiplier <= trace_trigger_pkg::RST_SAMPLE_MULT;
            st_r.pretrigger_percent       <= trace_trigger_pkg::RST_PRETRIG_PCT;
            st_r.state                    <= trace_trigger_pkg::ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready      = !st_r.aw_held;
    assign s_axi_wready       = !st_r.w_held;
    assign s_axi_bvalid       = st_r.bvalid;
    assign s_axi_bresp        = st_r.bresp;
    assign s_axi_arready      = !st_r.rvalid;
    assign s_axi_rvalid       = st_r.rvalid;
    assign s_axi_rdata        = st_r.rdata;
    assign s_axi_rresp        = st_r.rresp;
    assign source_select      = st_r.trigger_source_select;
    assign trace_enable       = tracing;
    assign sample_tick        = tick;
    assign trigger_event      = st_r.trig_pulse;
    assign triggered          = st_r.state == trace_trigger_pkg::ST_FIRED;
    assign pretrigger_percent = st_r.pretrigger_percent;

    a_trig_on_tick: assert property (@(posedge aclk) disable iff (!aresetn)
        trigger_event |-> $past(tick) && $past(cond_true))
        else $error("trigger without tick and true condition");
    a_trig_needs_trace: assert property (@(posedge aclk) disable iff (!aresetn)
        trigger_event |-> $past(tracing))
        else $error("trigger while tracing disabled");
    a_fire_latches: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r.state == trace_trigger_pkg::ST_ARMED && tracing && tick && cond_true) |=> triggered && trigger_event)
        else $error("true condition did not fire");
    a_single_event: assert property (@(posedge aclk) disable iff (!aresetn)
        trigger_event |=> !trigger_event)
        else $error("trigger pulse longer than one cycle");
    a_force_cond: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r.trigger_condition_select == trace_trigger_pkg::COND_FORCE) |-> cond_true)
        else $error("force condition not true");
    a_none_source: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r.trigger_source_select == trace_trigger_pkg::SRC_NONE &&
         st_r.trigger_condition_select < trace_trigger_pkg::COND_FAULT) |-> !cond_true)
        else $error("compare true with no source");
    a_eq_compare: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r.trigger_condition_select == trace_trigger_pkg::COND_EQ &&
         st_r.trigger_source_select != trace_trigger_pkg::SRC_NONE) |->
        cond_true == (source_value == st_r.trigger_compare_value))
        else $error("equal compare wrong");
    a_bit_test: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r.trigger_source_select == trace_trigger_pkg::SRC_DIN_STATUS &&
         st_r.trigger_condition_select == trace_trigger_pkg::COND_BIT0) |-> cond_true == source_value[0])
        else $error("bit test wrong");
    a_pct_range: assert property (@(posedge aclk) disable iff (!aresetn)
        pretrigger_percent <= trace_trigger_pkg::MAX_PRETRIG_PCT)
        else $error("pretrigger percent out of range");

    c_fire: cover property (@(posedge aclk) disable iff (!aresetn) trigger_event);
    c_tick: cover property (@(posedge aclk) disable iff (!aresetn) tick ##1 !tick);
    c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
    c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
endmodule

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
    localparam int unsigned BASE = 4;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [15:0] src_val = 16'h0;
    logic        fault = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, tr_en, tick, tev, trig;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [9:0]  src_sel;
    logic [6:0]  pre;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          ticks, fires, gap;
    // compare value is 100; last case: no source selected
    logic [4:0]  c_cond [14] = '{5'h0, 5'h0, 5'h1, 5'h2, 5'h2, 5'h3, 5'h4, 5'h4, 5'h5, 5'h14, 5'h14, 5'h5, 5'h15, 5'h0};
    logic [9:0]  c_src [14] = '{10'h2, 10'h2, 10'h2, 10'h2, 10'h2, 10'h2, 10'h2, 10'h2, 10'hb, 10'hc, 10'hc, 10'h2,
                                10'h0, 10'h0};
    logic [15:0] c_val [14] = '{16'h64, 16'h63, 16'h63, 16'h65, 16'hffff, 16'hffff, 16'h0, 16'h0, 16'h1, 16'h8000,
                                16'h7fff, 16'h1, 16'h0, 16'h64};
    logic        c_flt [14] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                1'b0};
    logic        c_exp [14] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1,
                                1'b0};

    always #4 aclk = ~aclk;

    trace_trigger_sampler #(.BASE_CYCLES(BASE)) uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .source_value(src_val), .fault_active(fault), .source_select(src_sel), .trace_enable(tr_en),
        .sample_tick(tick), .trigger_event(tev), .triggered(trig), .pretrigger_percent(pre)
    );

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // handshakes judged at the falling edge, where the rising-edge values stand settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       aw_hs;
        logic       w_hs;
        logic       b_hs;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_hs = awvalid & awready;
            w_hs = wvalid & wready;
            b_hs = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw_hs)
                awvalid <= 1'b0;
            if (w_hs)
                wvalid <= 1'b0;
        end while (b_hs !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic        ar_hs;
        logic        r_hs;
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_hs = arvalid & arready;
            r_hs = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_hs)
                arvalid <= 1'b0;
        end while (r_hs !== 1'b1);
        rready <= 1'b0;
        chk("rdata", ed, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask

    // counts high cycles, so a stretched pulse shows as more than one
    task automatic watch(input int lim);
        int t1;
        ticks = 0;
        fires = 0;
        gap = 0;
        t1 = 0;
        for (int i = 0; i < lim; i++) begin
            @(negedge aclk);
            if (tev === 1'b1)
                fires++;
            if (tick === 1'b1) begin
                ticks++;
                if (ticks == 1)
                    t1 = i;
                else if (ticks == 2)
                    gap = i - t1;
            end
        end
    endtask

    task automatic t_defaults();
        chk("source_select", 32'h0, {22'h0, src_sel});
        chk("pretrigger_percent", 32'h32, {25'h0, pre});
        chk("trace_enable", 32'h0, {31'h0, tr_en});
        rd(8'h04, 32'h0, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        rd(8'h0c, 32'h4, 2'h0);
        rd(8'h10, 32'h4, 2'h0);
        rd(8'h14, 32'h32, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
    endtask

    task automatic t_limits();
        wr(8'h04, 32'h3e8, 2'h2);
        wr(8'h04, 32'h3e7, 2'h0);
        wr(8'h0c, 32'h16, 2'h2);
        wr(8'h10, 32'h0, 2'h2);
        wr(8'h10, 32'h270f, 2'h0);
        wr(8'h14, 32'h65, 2'h2);
        wr(8'h14, 32'h64, 2'h0);
        rd(8'h04, 32'h3e7, 2'h0);
        rd(8'h10, 32'h270f, 2'h0);
        chk("source_select", 32'h3e7, {22'h0, src_sel});
        chk("pretrigger_percent", 32'h64, {25'h0, pre});
        wr(8'h10, 32'h1, 2'h0);
        wr(8'h08, 32'h64, 2'h0);
    endtask

    task automatic t_conds();
        for (int k = 0; k < 14; k++) begin
            wr(8'h0c, {27'h0, c_cond[k]}, 2'h0);
            wr(8'h04, {22'h0, c_src[k]}, 2'h0);
            @(posedge aclk);
            src_val <= c_val[k];
            fault <= c_flt[k];
            wr(8'h00, 32'h2, 2'h0);
            watch(4 * BASE);
            chk("trigger_pulses", {31'h0, c_exp[k]}, fires);
            chk("triggered", {31'h0, c_exp[k]}, {31'h0, trig});
            wr(8'h00, 32'h0, 2'h0);
        end
    endtask

    task automatic t_period();
        wr(8'h10, 32'h3, 2'h0);
        wr(8'h0c, 32'h4, 2'h0);
        wr(8'h00, 32'h3, 2'h0);
        chk("trace_enable", 32'h1, {31'h0, tr_en});
        watch(8 * BASE);
        chk("tick_gap", 3 * BASE, gap);
        rd(8'h1c, 32'h1, 2'h0);
        wr(8'h0c, 32'h15, 2'h0);
        wr(8'h00, 32'h1, 2'h0);
        watch(8 * BASE);
        chk("trace_enable", 32'h0, {31'h0, tr_en});
        chk("ticks_off", 32'h0, ticks);
        chk("pulses_off", 32'h0, fires);
        wr(8'h10, 32'h1, 2'h0);
    endtask

    task automatic t_latch();
        wr(8'h00, 32'h2, 2'h0);
        watch(10 * BASE);
        chk("pulses_latched", 32'h1, fires);
        rd(8'h1c, 32'h2, 2'h0);
        wr(8'h18, 32'h1, 2'h0);
        watch(4 * BASE);
        chk("pulses_rearmed", 32'h1, fires);
        wr(8'h00, 32'h0, 2'h0);
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_defaults();
        t_limits();
        t_conds();
        t_period();
        t_latch();
        end_of_test();
    end

    // the whole sequence needs about 700 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        end_of_test();
    end
endmodule
